/* pkg/vlan_diffserv_params.svh */
`ifndef VLAN_DIFFSERV_PARAMS_SVH
`define VLAN_DIFFSERV_PARAMS_SVH

// ----------------------------------------------------------------
// register numbers
// ----------------------------------------------------------------
`define VDT_REG_VLAN_STATUS 16'h1810
`define VDT_REG_PRIO_CMD 16'h1811
`define VDT_REG_PRIO_WDATA 16'h1812
`define VDT_REG_PRIO_RDATA 16'h1813
`define VDT_REG_PRIO_STATUS 16'h1814

// ----------------------------------------------------------------
// field positions and sizes
// ----------------------------------------------------------------
`define VDT_RNW_BIT 7
`define VDT_PEND_BIT 0
`define VDT_PRIO_W 3
`define VDT_VID_W 12
`define VDT_FLAG_BASE 12
`define VDT_ENTRY_W 18
`define VDT_PORTS 3
`define VDT_VLAN_ENTRIES 16
`define VDT_PRIO_ENTRIES 64
`define VDT_RESET_VAL 32'h0000_0000

`endif

/* pkg/vlan_diffserv_pkg.sv */
package vlan_diffserv_pkg;

  // gray along idle -> access -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_DONE = 2'b11
  } prio_state_t;

  typedef logic [2:0] port_vec_t;

endpackage

/* verilog/vlan_diffserv_table_access.sv */
`timescale 1ns/1ps
`include "vlan_diffserv_params.svh"

// Summary of operation
// - entry low twelve bits hold vlan identifier
// - per-port member and strip flags, reset clear
// - member admits ingress; else admit-nonmember option
// - ingress port's strip flag removes tag on every hybrid egress port
// - vlan pending flag set during access, self-clears
// - command register write launches table access
// - bit seven: one reads, zero writes
// - six-bit index selects table entry
// - read completion shown by pending flag clearing
// - table maps ToS/class to receive priority
// - write data priority stored on write command
// - read data shows last completed read
// - priority table not initialised at reset
module vlan_diffserv_table_access
  import vlan_diffserv_pkg::*;
#(
  parameter int VLAN_ENTRIES = `VDT_VLAN_ENTRIES,
  parameter int PRIO_ENTRIES = `VDT_PRIO_ENTRIES
) (
  input wire logic REF_CLK, // 10 MHz system clock
  input wire logic RST_B, // async reset, active low
  input wire logic CE, // clock enable, freezes state when low
  input wire logic [15:0] REG_ADDR, // register number
  input wire logic [31:0] REG_WDATA, // register write data
  input wire logic REG_WR, // register write strobe
  input wire logic REG_RD, // register read strobe
  output logic [31:0] REG_RDATA, // read data, one cycle after strobe
  input wire logic VLAN_CMD_GO, // vlan table command strobe
  input wire logic VLAN_CMD_RNW, // vlan command: 1 read, 0 write
  input wire logic [$clog2(VLAN_ENTRIES)-1:0] VLAN_CMD_INDEX, // entry
  input wire logic [`VDT_ENTRY_W-1:0] VLAN_WDATA, // entry to write
  output logic [`VDT_ENTRY_W-1:0] VLAN_RDATA, // entry last read
  input wire logic [`VDT_VID_W-1:0] ING_VID, // ingress frame vid
  input wire logic [1:0] ING_PORT, // ingress port number
  input wire logic [2:0] ADMIT_NONMEMBER, // admit_nonmember_cfg
  input wire logic [2:0] EGRESS_HYBRID, // egress_port_type_cfg
  output logic ING_ADMIT, // ingress frame admitted
  output logic [2:0] EGRESS_MEMBERS, // broadcast domain ports
  output logic [2:0] STRIP_PORTS, // egress ports removing tag
  input wire logic [$clog2(PRIO_ENTRIES)-1:0] TOS_INDEX, // rx ToS/class
  output logic [`VDT_PRIO_W-1:0] RX_PRIORITY // mapped priority
);

  localparam int VIDX_W = $clog2(VLAN_ENTRIES);
  localparam int PIDX_W = $clog2(PRIO_ENTRIES);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // illegal port numbers select nothing
  function automatic logic port_bit(port_vec_t vec, logic [1:0] port);
    port_bit = (port < 2'(`VDT_PORTS)) ? vec[port] : 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // vlan table
  // ----------------------------------------------------------------
  logic [`VDT_ENTRY_W-1:0] vlan_table [VLAN_ENTRIES];
  logic vlan_pend;
  logic vlan_rnw;
  logic [VIDX_W-1:0] vlan_index;
  logic [`VDT_ENTRY_W-1:0] vlan_wdata;

  // one access cycle; strobes while pending are dropped
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      vlan_pend <= 1'b0;
      vlan_rnw <= 1'b0;
      vlan_index <= '0;
      vlan_wdata <= '0;
    end else if (CE) begin
      if (vlan_pend) begin
        vlan_pend <= 1'b0;
      end else if (VLAN_CMD_GO) begin
        vlan_pend <= 1'b1;
        vlan_rnw <= VLAN_CMD_RNW;
        vlan_index <= VLAN_CMD_INDEX;
        vlan_wdata <= VLAN_WDATA;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < VLAN_ENTRIES; i++) begin
        vlan_table[i] <= '0;
      end
      VLAN_RDATA <= '0;
    end else if (CE && vlan_pend) begin
      if (vlan_rnw) begin
        VLAN_RDATA <= vlan_table[vlan_index];
      end else begin
        vlan_table[vlan_index] <= vlan_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // vlan match and port flags
  // ----------------------------------------------------------------
  logic [VLAN_ENTRIES-1:0] vid_hit;
  port_vec_t hit_member;
  port_vec_t hit_strip;

  for (genvar g = 0; g < VLAN_ENTRIES; g++) begin : g_match
    assign vid_hit[g] = vlan_table[g][`VDT_VID_W-1:0] == ING_VID;
  end

  always_comb begin
    hit_member = '0;
    hit_strip = '0;
    for (int i = 0; i < VLAN_ENTRIES; i++) begin
      for (int p = 0; p < `VDT_PORTS; p++) begin
        if (vid_hit[i]) begin
          hit_member[p] = hit_member[p] |
            vlan_table[i][`VDT_FLAG_BASE + 2 * p + 1];
          hit_strip[p] = hit_strip[p] |
            vlan_table[i][`VDT_FLAG_BASE + 2 * p];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ING_ADMIT <= 1'b0;
      EGRESS_MEMBERS <= '0;
      STRIP_PORTS <= '0;
    end else if (CE) begin
      ING_ADMIT <= port_bit(hit_member, ING_PORT) |
        port_bit(ADMIT_NONMEMBER, ING_PORT);
      EGRESS_MEMBERS <= hit_member;
      STRIP_PORTS <= EGRESS_HYBRID &
        {3{port_bit(hit_strip, ING_PORT)}};
    end
  end

  // ----------------------------------------------------------------
  // priority table access
  // ----------------------------------------------------------------
  // no reset on the array: contents are undefined until written
  logic [`VDT_PRIO_W-1:0] prio_table [PRIO_ENTRIES];
  prio_state_t state;
  logic pending;
  logic cmd_rnw;
  logic [PIDX_W-1:0] cmd_index;
  logic [`VDT_PRIO_W-1:0] wr_prio;
  logic [`VDT_PRIO_W-1:0] rd_prio;
  logic [`VDT_PRIO_W-1:0] rx_lookup;
  logic cmd_accept;
  logic [31:0] next_rdata;

  assign pending = state != ST_IDLE;
  // a command written while busy is dropped whole
  assign cmd_accept = CE && REG_WR && REG_ADDR == `VDT_REG_PRIO_CMD &&
    state == ST_IDLE;
  assign rx_lookup = prio_table[TOS_INDEX];

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (CE) begin
      unique case (state)
        ST_IDLE: begin
          if (cmd_accept) begin
            state <= ST_ACCESS;
          end
        end
        ST_ACCESS: state <= ST_DONE;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rnw <= 1'b0;
      cmd_index <= '0;
    end else if (cmd_accept) begin
      cmd_rnw <= REG_WDATA[`VDT_RNW_BIT];
      cmd_index <= REG_WDATA[PIDX_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_prio <= '0;
    end else if (CE && REG_WR && REG_ADDR == `VDT_REG_PRIO_WDATA) begin
      wr_prio <= REG_WDATA[`VDT_PRIO_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (rst_n && CE && state == ST_ACCESS && !cmd_rnw) begin
      prio_table[cmd_index] <= wr_prio;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rd_prio <= '0;
      RX_PRIORITY <= '0;
    end else if (CE) begin
      if (state == ST_ACCESS && cmd_rnw)
        rd_prio <= prio_table[cmd_index];
      RX_PRIORITY <= rx_lookup;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = `VDT_RESET_VAL;
    unique case (REG_ADDR)
      `VDT_REG_VLAN_STATUS: next_rdata[`VDT_PEND_BIT] = vlan_pend;
      `VDT_REG_PRIO_CMD: begin
        next_rdata[`VDT_RNW_BIT] = cmd_rnw;
        next_rdata[PIDX_W-1:0] = cmd_index;
      end
      `VDT_REG_PRIO_WDATA: next_rdata[`VDT_PRIO_W-1:0] = wr_prio;
      `VDT_REG_PRIO_RDATA: next_rdata[`VDT_PRIO_W-1:0] = rd_prio;
      `VDT_REG_PRIO_STATUS: next_rdata[`VDT_PEND_BIT] = pending;
      default: next_rdata = `VDT_RESET_VAL;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA <= `VDT_RESET_VAL;
    end else if (CE && REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_vlan_launch;
    @(posedge REF_CLK) disable iff (!rst_n)
      CE && VLAN_CMD_GO && !vlan_pend |=> vlan_pend;
  endproperty
  a_vlan_launch: assert property (p_vlan_launch)
    else $error("vlan command did not raise pending");
  property p_vlan_selfclear;
    @(posedge REF_CLK) disable iff (!rst_n)
      CE && vlan_pend |=> !vlan_pend;
  endproperty
  a_vlan_selfclear: assert property (p_vlan_selfclear)
    else $error("vlan pending did not clear");
  property p_vlan_write;
    @(posedge REF_CLK) disable iff (!rst_n)
      CE && vlan_pend && !vlan_rnw |=>
        vlan_table[$past(vlan_index)] == $past(vlan_wdata);
  endproperty
  a_vlan_write: assert property (p_vlan_write)
    else $error("vlan entry not stored");
  property p_launch;
    @(posedge REF_CLK) disable iff (!rst_n)
      cmd_accept |=> pending && cmd_rnw == $past(REG_WDATA[7]);
  endproperty
  a_launch: assert property (p_launch)
    else $error("command write did not launch access");
  property p_index;
    @(posedge REF_CLK) disable iff (!rst_n)
      cmd_accept |=> cmd_index == $past(REG_WDATA[5:0]);
  endproperty
  a_index: assert property (p_index)
    else $error("command index not captured");
  property p_done_clears;
    @(posedge REF_CLK) disable iff (!rst_n)
      CE && state == ST_DONE |=> !pending;
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("pending not cleared after command");
  property p_read_result;
    @(posedge REF_CLK) disable iff (!rst_n)
      state == ST_DONE && cmd_rnw |-> rd_prio == prio_table[cmd_index];
  endproperty
  a_read_result: assert property (p_read_result)
    else $error("read data differs from table entry");
  property p_write_store;
    @(posedge REF_CLK) disable iff (!rst_n)
      state == ST_DONE && !cmd_rnw |-> prio_table[cmd_index] == wr_prio;
  endproperty
  a_write_store: assert property (p_write_store)
    else $error("write data not stored in table");
  // sampled rst_n skips the release edge; unfilled entries stay x
  property p_rx_map;
    @(posedge REF_CLK) disable iff (!rst_n)
      CE && rst_n |=> RX_PRIORITY === $past(rx_lookup);
  endproperty
  a_rx_map: assert property (p_rx_map)
    else $error("receive priority not from table");
  property p_admit;
    @(posedge REF_CLK) disable iff (!rst_n)
      CE && rst_n && port_bit(ADMIT_NONMEMBER, ING_PORT) |=> ING_ADMIT;
  endproperty
  a_admit: assert property (p_admit)
    else $error("non-member option did not admit frame");
  property p_reserved;
    @(posedge REF_CLK) disable iff (!rst_n)
      CE && REG_RD && REG_ADDR == `VDT_REG_PRIO_CMD |=>
        REG_RDATA[31:8] == 24'h0 && !REG_RDATA[6];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved command bits not zero");

  c_read_cmd: cover property (@(posedge REF_CLK) disable iff (!rst_n)
    state == ST_DONE && cmd_rnw);
  c_write_cmd: cover property (@(posedge REF_CLK) disable iff (!rst_n)
    state == ST_DONE && !cmd_rnw);
  c_vlan_op: cover property (@(posedge REF_CLK) disable iff (!rst_n)
    vlan_pend && !vlan_rnw);
  c_strip: cover property (@(posedge REF_CLK) disable iff (!rst_n)
    STRIP_PORTS != 3'h0);

endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
`include "vlan_diffserv_params.svh"

module tb_top;
  import vlan_diffserv_pkg::*;

  typedef struct packed {
    logic [5:0] idx;
    logic [2:0] prio;
  } row_t;

  logic REF_CLK, RST_B, CE, REG_WR, REG_RD, VLAN_CMD_GO, VLAN_CMD_RNW;
  logic [15:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, d;
  logic [3:0] VLAN_CMD_INDEX;
  logic [17:0] VLAN_WDATA, VLAN_RDATA;
  logic [11:0] ING_VID;
  logic [1:0] ING_PORT;
  logic [2:0] ADMIT_NONMEMBER, EGRESS_HYBRID, EGRESS_MEMBERS, STRIP_PORTS;
  logic [2:0] RX_PRIORITY;
  logic [5:0] TOS_INDEX;
  logic ING_ADMIT;
  int n_fail = 0;
  int tests_run = 0;
  row_t rows[4] = '{'{6'h00, 3'h5}, '{6'h3f, 3'h2}, '{6'h15, 3'h7},
                    '{6'h2a, 3'h0}};

  vlan_diffserv_table_access i_vlan_diffserv_table_access (
    .REF_CLK(REF_CLK), .RST_B(RST_B), .CE(CE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .VLAN_CMD_GO(VLAN_CMD_GO),
    .VLAN_CMD_RNW(VLAN_CMD_RNW), .VLAN_CMD_INDEX(VLAN_CMD_INDEX),
    .VLAN_WDATA(VLAN_WDATA), .VLAN_RDATA(VLAN_RDATA), .ING_VID(ING_VID),
    .ING_PORT(ING_PORT), .ADMIT_NONMEMBER(ADMIT_NONMEMBER),
    .EGRESS_HYBRID(EGRESS_HYBRID), .ING_ADMIT(ING_ADMIT),
    .EGRESS_MEMBERS(EGRESS_MEMBERS), .STRIP_PORTS(STRIP_PORTS),
    .TOS_INDEX(TOS_INDEX), .RX_PRIORITY(RX_PRIORITY)
  );

  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge REF_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
  endtask

  // data registered at the taking edge, sampled half a cycle later
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge REF_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    @(negedge REF_CLK);
    v = REG_RDATA;
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 10 && s[0] !== 1'b0; i++) rd(16'h1814, s);
    chk(s, 32'h0);
  endtask

  // status read lands in the single pending cycle of the vlan port
  task automatic vlan_cmd(input logic read_not_write, input logic [3:0] idx,
                          input logic [17:0] v);
    @(posedge REF_CLK);
    VLAN_CMD_GO <= 1'b1;
    VLAN_CMD_RNW <= read_not_write;
    VLAN_CMD_INDEX <= idx;
    VLAN_WDATA <= v;
    @(posedge REF_CLK);
    VLAN_CMD_GO <= 1'b0;
    REG_RD <= 1'b1;
    REG_ADDR <= 16'h1810;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    @(negedge REF_CLK);
    chk(REG_RDATA, 32'h1);
    repeat (2) @(posedge REF_CLK);
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge REF_CLK);
    n_fail++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    RST_B = 1'b0;
    CE = 1'b1;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 16'h0;
    REG_WDATA = 32'h0;
    VLAN_CMD_GO = 1'b0;
    VLAN_CMD_RNW = 1'b0;
    VLAN_CMD_INDEX = 4'h0;
    VLAN_WDATA = 18'h0;
    ING_VID = 12'h0;
    ING_PORT = 2'h3;
    ADMIT_NONMEMBER = 3'h0;
    EGRESS_HYBRID = 3'h0;
    TOS_INDEX = 6'h0;
    repeat (10) @(posedge REF_CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    for (int a = 16'h1810; a <= 16'h1814; a++) begin
      rd(a[15:0], d);
      chk(d, 32'h0);
    end
    // fill every entry first: the table powers up undefined
    for (int i = 0; i < 64; i++) begin
      wr(16'h1812, {29'h0, 3'(i)});
      wr(16'h1811, {26'h0, 6'(i)});
      wait_idle();
    end
    // table rows: write, read back, then look up by ToS index
    foreach (rows[k]) begin
      wr(16'h1812, {29'h0, rows[k].prio});
      wr(16'h1811, {24'h0, 2'b00, rows[k].idx});
      wait_idle();
      wr(16'h1811, {24'h0, 2'b10, rows[k].idx});
      wait_idle();
      rd(16'h1813, d);
      chk(d, {29'h0, rows[k].prio});
      @(posedge REF_CLK);
      TOS_INDEX <= rows[k].idx;
      repeat (2) @(posedge REF_CLK);
      @(negedge REF_CLK);
      chk(RX_PRIORITY, rows[k].prio);
    end
    // reserved bits dropped on write, read as zero
    wr(16'h1812, 32'hffff_fffd);
    rd(16'h1812, d);
    chk(d, 32'h5);
    wr(16'h1811, 32'hffff_ff7f);
    rd(16'h1811, d);
    chk(d, 32'h3f);
    wait_idle();
    wr(16'h1813, 32'h7);
    rd(16'h1813, d);
    chk(d, {29'h0, rows[3].prio});
    rd(16'h1900, d);
    chk(d, 32'h0);
    // frozen clock enable ignores the write
    @(posedge REF_CLK);
    CE <= 1'b0;
    wr(16'h1812, 32'h1);
    CE <= 1'b1;
    rd(16'h1812, d);
    chk(d, 32'h5);
    // back-to-back command while busy is refused
    wr(16'h1812, 32'h3);
    wr(16'h1811, 32'h09);
    rd(16'h1814, d);
    chk(d, 32'h1);
    wait_idle();
    wr(16'h1811, 32'h09);
    wr(16'h1811, 32'h8a);
    wait_idle();
    rd(16'h1811, d);
    chk(d, 32'h09);
    @(posedge REF_CLK);
    TOS_INDEX <= 6'h09;
    repeat (2) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk(RX_PRIORITY, 3'h3);
    // vlan entry: member p2 and p0, strip p0, vid 0x123
    vlan_cmd(1'b0, 4'h5, 18'h2_3123);
    vlan_cmd(1'b1, 4'h5, 18'h0);
    chk(VLAN_RDATA, 18'h2_3123);
    ING_VID <= 12'h123;
    ING_PORT <= 2'h0;
    EGRESS_HYBRID <= 3'b110;
    repeat (2) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk(ING_ADMIT, 1'b1);
    chk(EGRESS_MEMBERS, 3'b101);
    chk(STRIP_PORTS, 3'b110);
    @(posedge REF_CLK);
    ING_PORT <= 2'h1;
    repeat (2) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk(ING_ADMIT, 1'b0);
    chk(STRIP_PORTS, 3'b000);
    @(posedge REF_CLK);
    ADMIT_NONMEMBER <= 3'b010;
    repeat (2) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk(ING_ADMIT, 1'b1);
    // mid-run reset: registers and vlan table clear, priority table stays
    @(posedge REF_CLK);
    RST_B <= 1'b0;
    repeat (10) @(posedge REF_CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    rd(16'h1812, d);
    chk(d, 32'h0);
    chk(VLAN_RDATA, 18'h0);
    chk(EGRESS_MEMBERS, 3'h0);
    chk(RX_PRIORITY, 3'h3);
    finish_test();
  end
endmodule
